// *** logic/pport_pkg.sv ***
// package for the buffered parallel slave port: register map, fields, reset values
// assumes a 32-bit Avalon-MM register bus with word-aligned registers
package pport_pkg;
    // register byte addresses (word index times four where the index is not aligned)
    localparam logic [11:0] ADDR_LOW_IDX    = 12'hf6e;
    localparam logic [11:0] ADDR_HIGH_IDX   = 12'hf6f;
    localparam logic [13:0] OFF_ADDR_LOW    = 14'(ADDR_LOW_IDX) * 14'h0004;
    localparam logic [13:0] OFF_ADDR_HIGH   = 14'(ADDR_HIGH_IDX) * 14'h0004;
    localparam logic [13:0] OFF_CONTROL     = 14'h0000;
    localparam logic [13:0] OFF_MODE        = 14'h0004;
    localparam logic [13:0] OFF_STAT_LOW    = 14'h0008;
    localparam logic [13:0] OFF_STAT_HIGH   = 14'h000c;
    localparam logic [13:0] OFF_IN_BASE     = 14'h0010;
    localparam logic [13:0] OFF_OUT2_LOW    = 14'h0020;
    localparam logic [13:0] OFF_OUT2_HIGH   = 14'h0024;
    localparam logic [13:0] OFF_IRQ         = 14'h0028;
    // control register fields
    localparam int CTL_ENABLE  = 0;
    localparam int CTL_CS_POL  = 1;
    localparam int CTL_RD_POL  = 2;
    localparam int CTL_WR_POL  = 3;
    localparam int CTL_CSF_LO  = 4; // chip select configuration, two bits
    // mode register fields
    localparam int MODE_LO     = 0;
    localparam int INCREMENT_MODE_FIELD_LO     = 3;
    localparam int INTERRUPT_MODE_FIELD_LO     = 6;
    localparam logic [1:0] MODE_LEGACY  = 2'h0;
    localparam logic [1:0] INCREMENT_MODE_FIELD_BUFFER  = 2'h3;
    localparam logic [1:0] INTERRUPT_MODE_FIELD_EVERY   = 2'h1;
    localparam logic [1:0] INTERRUPT_MODE_FIELD_FOURTH  = 2'h3;
    localparam logic [1:0] CSF_CONTROL  = 2'h2;
    // status and address high bit positions, last slot, reset byte
    localparam int ST_ALL      = 7;
    localparam int ST_ERR      = 6;
    localparam int ADDRH_CS    = 6;
    localparam logic [1:0] LAST_SLOT = 2'h3;
    localparam logic [7:0] RST_BYTE  = 8'h00;
endpackage

// *** logic/parallel_slave_port_buffered.sv ***
// parallel slave port with four-deep buffered mode, one system clock
// assumes asynchronous external strobes and an Avalon-MM master on the register side
`timescale 1ns/1ps
// Behaviour
// - mode 00 with enable set makes the port a slave on the 8-bit bus
// - legacy: chip select with write strobe captures the bus into input byte zero
// - legacy: each completed external write sets the interrupt flag and input full status
// - legacy: chip select with read strobe drives output byte zero onto the bus
// - chip select, read and write strobe polarities are configurable
// - increment mode 11 selects four-level buffered slave mode
// - buffered: input bytes are write buffers, output bytes read buffers, 0 to 3
// - each buffered read strobe outputs the next read buffer by an internal pointer
// - read buffer empty bit clears on load and sets once presented on the bus
// - reading an empty read buffer sets the output underflow flag
// - all-outputs-empty is set while all four empty bits are set
// - buffered writes fill write buffers 0 to 3 by an internal pointer
// - write buffer full bit sets on its write strobe, clears on software read
// - writing a full write buffer sets input overflow and loses the data
// - all-inputs-full is set while all four full bits are set in buffered mode, while full bit 0 is set in legacy
// - buffered: interrupt mode 01 raises an interrupt on every read or write strobe
// - buffered: interrupt mode 11 interrupts only on read buffer 3 or write buffer 3
// - address high bit 6 is chip select control in config 10, else address bit 14
// - address registers hold address bits, and act as output bytes zero and one in slave mode
// - input overflow stays set until software clears it
module parallel_slave_port_buffered (
    // system
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // avalon-mm slave
    input  wire logic [13:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic      [1:0]  response,
    // parallel port pins
    input  wire logic        portChipSelect,
    input  wire logic        portReadStrobe,
    input  wire logic        portWriteStrobe,
    input  wire logic [7:0]  portDataBusIn,
    output logic      [7:0]  portDataBusOut,
    output logic             portDataBusOe,
    output logic             portChipSelectOne,
    output logic             portInterruptFlag
);
    typedef enum logic [1:0] {BUS_IDLE, BUS_DONE} bus_state_t;

    logic [7:0]  control_reg;
    logic [7:0]  mode_reg;
    logic [7:0]  addrLow_reg;
    logic [7:0]  addrHigh_reg;
    logic [7:0]  out2Low_reg;
    logic [7:0]  out2High_reg;
    logic [7:0]  inByte_reg [4];
    logic [3:0]  inFull_reg;
    logic [3:0]  outEmpty_reg;
    logic        inOverflow_reg;
    logic        outUnderflow_reg;
    logic        irqFlag_reg;
    logic [1:0]  rdPtr_reg;
    logic [1:0]  wrPtr_reg;
    logic [2:0]  csSync_reg;
    logic [2:0]  rdSync_reg;
    logic [2:0]  wrSync_reg;
    logic [7:0]  dataSync1_reg;
    logic [7:0]  dataSync2_reg;
    logic        csState_reg;
    logic        rdState_reg;
    logic        wrState_reg;
    bus_state_t  busState_reg;
    logic [31:0] readdata_next;

    // pin filter: a change counts once the second and third stages agree
    function automatic logic filtered(input logic [2:0] s, input logic prev);
        filtered = (s[1] == s[2]) ? s[1] : prev;
    endfunction

    // current output byte by slot number
    function automatic logic [7:0] outSlot(input logic [1:0] idx, input logic [7:0] a,
                                           input logic [7:0] b, input logic [7:0] c,
                                           input logic [7:0] d);
        unique case (idx)
            2'h0: outSlot = a;
            2'h1: outSlot = b;
            2'h2: outSlot = c;
            2'h3: outSlot = d;
        endcase
    endfunction

    // register offset hit
    function automatic logic hit(input logic [13:0] a, input logic [13:0] off);
        hit = (a == off);
    endfunction

    logic enabled;
    logic buffered;
    logic csActive;
    logic rdActive;
    logic wrActive;
    logic wrEnd;
    logic rdStart;
    logic rdEnd;
    logic busRead;
    logic busWrite;
    logic [1:0] curWr;
    logic [1:0] curRd;
    logic [7:0] curOut;

    assign enabled  = control_reg[pport_pkg::CTL_ENABLE]
                    && mode_reg[pport_pkg::MODE_LO +: 2] == pport_pkg::MODE_LEGACY;
    assign buffered = mode_reg[pport_pkg::INCREMENT_MODE_FIELD_LO +: 2] == pport_pkg::INCREMENT_MODE_FIELD_BUFFER;
    // polarity: a set bit means active high
    assign csActive = csState_reg == control_reg[pport_pkg::CTL_CS_POL];
    assign rdActive = rdState_reg == control_reg[pport_pkg::CTL_RD_POL];
    assign wrActive = wrState_reg == control_reg[pport_pkg::CTL_WR_POL];
    assign curWr    = buffered ? wrPtr_reg : 2'h0;
    assign curRd    = buffered ? rdPtr_reg : 2'h0;
    assign curOut   = outSlot(curRd, addrLow_reg, addrHigh_reg, out2Low_reg, out2High_reg);
    assign busRead  = read && busState_reg == BUS_DONE;
    assign busWrite = write && busState_reg == BUS_DONE;

    // three-stage synchronisers on the strobes, two stages on the data bus
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            csSync_reg    <= 3'h0;
            rdSync_reg    <= 3'h0;
            wrSync_reg    <= 3'h0;
            dataSync1_reg <= 8'h00;
            dataSync2_reg <= 8'h00;
        end
        else
        begin
            csSync_reg    <= {csSync_reg[1:0], portChipSelect};
            rdSync_reg    <= {rdSync_reg[1:0], portReadStrobe};
            wrSync_reg    <= {wrSync_reg[1:0], portWriteStrobe};
            dataSync1_reg <= portDataBusIn;
            dataSync2_reg <= dataSync1_reg;
        end
    end

    // filtered strobe levels; the previous level is held, and reset loads low
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            csState_reg <= 1'b0;
            rdState_reg <= 1'b0;
            wrState_reg <= 1'b0;
        end
        else
        begin
            csState_reg <= filtered(csSync_reg, csState_reg);
            rdState_reg <= filtered(rdSync_reg, rdState_reg);
            wrState_reg <= filtered(wrSync_reg, wrState_reg);
        end
    end

    // strobe transitions, qualified by chip select and enable
    logic rdNow;
    logic wrNow;
    logic rdSeen_reg;
    logic wrSeen_reg;
    assign rdNow   = enabled && csActive && rdActive;
    assign wrNow   = enabled && csActive && wrActive;
    assign rdStart = rdNow && !rdSeen_reg;
    assign rdEnd   = !rdNow && rdSeen_reg;
    assign wrEnd   = !wrNow && wrSeen_reg;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdSeen_reg <= 1'b0;
            wrSeen_reg <= 1'b0;
        end
        else
        begin
            rdSeen_reg <= rdNow;
            wrSeen_reg <= wrNow;
        end
    end

    // write data latch while the write strobe is active; full buffer drops the byte
    logic [7:0] wrData_reg;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            wrData_reg <= pport_pkg::RST_BYTE;
        else if (wrNow)
            wrData_reg <= dataSync2_reg;
    end

    // write buffers and their full bits
    for (genvar i = 0; i < 4; i++)
    begin : gInBuf
        logic swRd;
        assign swRd = busRead && hit(address, pport_pkg::OFF_IN_BASE + 14'(4 * i));
        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                inByte_reg[i] <= pport_pkg::RST_BYTE;
                inFull_reg[i] <= 1'b0;
            end
            else if (wrEnd && curWr == 2'(i))
            begin
                if (!inFull_reg[i])
                    inByte_reg[i] <= wrData_reg;
                inFull_reg[i] <= 1'b1;
            end
            else if (swRd)
                inFull_reg[i] <= 1'b0;
        end
    end

    // buffer pointers, wrapping 3 to 0
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPtr_reg <= 2'h0;
            rdPtr_reg <= 2'h0;
        end
        else
        begin
            if (!buffered)
                wrPtr_reg <= 2'h0;
            else if (wrEnd)
                wrPtr_reg <= wrPtr_reg + 2'h1;
            if (!buffered)
                rdPtr_reg <= 2'h0;
            else if (rdEnd)
                rdPtr_reg <= rdPtr_reg + 2'h1;
        end
    end

    // data bus drive while the external read is active
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            portDataBusOut <= 8'h00;
            portDataBusOe  <= 1'b0;
        end
        else
        begin
            portDataBusOut <= curOut;
            portDataBusOe  <= rdNow;
        end
    end

    // output empty bits: set on presenting, cleared by software load
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            outEmpty_reg <= 4'hf;
        else
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (rdStart && curRd == 2'(k))
                    outEmpty_reg[k] <= 1'b1;
                else if (busWrite && k == 0 && hit(address, pport_pkg::OFF_ADDR_LOW))
                    outEmpty_reg[k] <= 1'b0;
                else if (busWrite && k == 1 && hit(address, pport_pkg::OFF_ADDR_HIGH))
                    outEmpty_reg[k] <= 1'b0;
                else if (busWrite && k == 2 && hit(address, pport_pkg::OFF_OUT2_LOW))
                    outEmpty_reg[k] <= 1'b0;
                else if (busWrite && k == 3 && hit(address, pport_pkg::OFF_OUT2_HIGH))
                    outEmpty_reg[k] <= 1'b0;
            end
        end
    end

    // sticky error flags: set wins over a software clear
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            inOverflow_reg   <= 1'b0;
            outUnderflow_reg <= 1'b0;
        end
        else
        begin
            if (wrEnd && inFull_reg[curWr])
                inOverflow_reg <= 1'b1;
            else if (busWrite && hit(address, pport_pkg::OFF_STAT_HIGH)
                     && byteenable[0] && !writedata[pport_pkg::ST_ERR])
                inOverflow_reg <= 1'b0;
            if (rdStart && outEmpty_reg[curRd])
                outUnderflow_reg <= 1'b1;
            else if (busWrite && hit(address, pport_pkg::OFF_STAT_LOW)
                     && byteenable[0] && !writedata[pport_pkg::ST_ERR])
                outUnderflow_reg <= 1'b0;
        end
    end

    // interrupt flag: legacy every write, buffered by interrupt mode
    logic irqEvent;
    logic [1:0] interrupt_mode_field;
    assign interrupt_mode_field = mode_reg[pport_pkg::INTERRUPT_MODE_FIELD_LO +: 2];
    always_comb
    begin
        irqEvent = 1'b0;
        if (!buffered)
            irqEvent = wrEnd;
        else if (interrupt_mode_field == pport_pkg::INTERRUPT_MODE_FIELD_EVERY)
            irqEvent = wrEnd || rdEnd;
        else if (interrupt_mode_field == pport_pkg::INTERRUPT_MODE_FIELD_FOURTH)
            irqEvent = (wrEnd && wrPtr_reg == pport_pkg::LAST_SLOT)
                    || (rdEnd && rdPtr_reg == pport_pkg::LAST_SLOT);
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            irqFlag_reg <= 1'b0;
        else if (irqEvent)
            irqFlag_reg <= 1'b1;
        else if (busWrite && hit(address, pport_pkg::OFF_IRQ) && byteenable[0]
                 && writedata[0])
            irqFlag_reg <= 1'b0; // write one to clear
    end

    // software registers: control, mode, address/output bytes
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            control_reg  <= pport_pkg::RST_BYTE;
            mode_reg     <= pport_pkg::RST_BYTE;
            addrLow_reg  <= pport_pkg::RST_BYTE;
            addrHigh_reg <= pport_pkg::RST_BYTE;
            out2Low_reg  <= pport_pkg::RST_BYTE;
            out2High_reg <= pport_pkg::RST_BYTE;
        end
        else if (busWrite && byteenable[0])
        begin
            if (hit(address, pport_pkg::OFF_CONTROL))
                control_reg <= writedata[7:0];
            if (hit(address, pport_pkg::OFF_MODE))
                mode_reg <= writedata[7:0];
            if (hit(address, pport_pkg::OFF_ADDR_LOW))
                addrLow_reg <= writedata[7:0];
            if (hit(address, pport_pkg::OFF_ADDR_HIGH))
                addrHigh_reg <= writedata[7:0];
            if (hit(address, pport_pkg::OFF_OUT2_LOW))
                out2Low_reg <= writedata[7:0];
            if (hit(address, pport_pkg::OFF_OUT2_HIGH))
                out2High_reg <= writedata[7:0];
        end
    end

    // chip select control output from address high bit 6
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            portChipSelectOne <= 1'b0;
        else
            portChipSelectOne <= control_reg[pport_pkg::CTL_CSF_LO +: 2]
                == pport_pkg::CSF_CONTROL && addrHigh_reg[pport_pkg::ADDRH_CS];
    end

    // read data mux
    always_comb
    begin
        readdata_next = 32'h0000_0000;
        unique case (address)
            pport_pkg::OFF_CONTROL:   readdata_next[7:0] = control_reg;
            pport_pkg::OFF_MODE:      readdata_next[7:0] = mode_reg;
            pport_pkg::OFF_ADDR_LOW:  readdata_next[7:0] = addrLow_reg;
            pport_pkg::OFF_ADDR_HIGH: readdata_next[7:0] = addrHigh_reg;
            pport_pkg::OFF_OUT2_LOW:  readdata_next[7:0] = out2Low_reg;
            pport_pkg::OFF_OUT2_HIGH: readdata_next[7:0] = out2High_reg;
            pport_pkg::OFF_STAT_LOW:  readdata_next[7:0] = {&outEmpty_reg,
                                          outUnderflow_reg, 2'h0, outEmpty_reg};
            pport_pkg::OFF_STAT_HIGH: readdata_next[7:0] = {buffered ? &inFull_reg : inFull_reg[0],
                                          inOverflow_reg, 2'h0, inFull_reg};
            pport_pkg::OFF_IRQ:       readdata_next[0] = irqFlag_reg;
            default:
            begin
                for (int k = 0; k < 4; k++)
                    if (hit(address, pport_pkg::OFF_IN_BASE + 14'(4 * k)))
                        readdata_next[7:0] = inByte_reg[k];
            end
        endcase
    end

    // bus handshake: every access answered one cycle after it is raised
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busState_reg <= BUS_IDLE;
            waitrequest  <= 1'b1;
            readdata     <= 32'h0000_0000;
            response     <= 2'h0;
        end
        else if (busState_reg == BUS_IDLE && (read || write))
        begin
            busState_reg <= BUS_DONE;
            waitrequest  <= 1'b0;
            readdata     <= readdata_next;
            response     <= 2'h0;
        end
        else
        begin
            busState_reg <= BUS_IDLE;
            waitrequest  <= 1'b1;
        end
    end

    // interrupt output
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            portInterruptFlag <= 1'b0;
        else
            portInterruptFlag <= irqFlag_reg;
    end

    // pointer wrap, full, overflow, underflow, empty, interrupt, bus drive and answer checks
    ptr_wrap_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (buffered && wrEnd && wrPtr_reg == 2'h3) |=> wrPtr_reg == 2'h0)
        else $error("write pointer did not wrap");
    full_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (wrEnd && curWr == 2'h0) |=> inFull_reg[0])
        else $error("full bit not set on write");
    overflow_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (wrEnd && inFull_reg[curWr])
        |=> inOverflow_reg && inByte_reg[$past(curWr)] == $past(inByte_reg[curWr]))
        else $error("overflow not flagged or data overwritten");
    overflow_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (inOverflow_reg && !(busWrite && hit(address, pport_pkg::OFF_STAT_HIGH)))
        |=> inOverflow_reg)
        else $error("overflow cleared by hardware");
    underflow_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (rdStart && outEmpty_reg[curRd]) |=> outUnderflow_reg)
        else $error("underflow not flagged");
    empty_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        rdStart |=> outEmpty_reg[$past(curRd)])
        else $error("empty bit not set after presenting");
    irq_every_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (buffered && interrupt_mode_field == pport_pkg::INTERRUPT_MODE_FIELD_EVERY && rdEnd) |-> ##2 portInterruptFlag)
        else $error("no interrupt on read strobe");
    bus_drive_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        rdNow |=> portDataBusOe && portDataBusOut == $past(curOut))
        else $error("bus not driven during read");
    answer_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (busState_reg == BUS_IDLE && read) |=> !waitrequest)
        else $error("bus access not answered");
endmodule

// *** verification/host_cpu_model.sv ***
// partner model: external processor driving the strobes and the data bus
// assumes the port samples the pins through synchronisers on core_clk
`timescale 1ns/1ps
module host_cpu_model (
    // clock
    input  wire logic       core_clk,
    // strobes toward the port
    output logic            portChipSelect,
    output logic            portReadStrobe,
    output logic            portWriteStrobe,
    // data bus, split into both directions
    output logic      [7:0] portDataBusIn,
    input  wire logic [7:0] portDataBusOut,
    input  wire logic       portDataBusOe
);
    logic       activeHigh;
    logic       drive;
    logic [7:0] driveData;
    logic [7:0] lastVal;

    // wire level: the driving party, else the inverse of the last value
    assign portDataBusIn = drive ? driveData : (portDataBusOe ? portDataBusOut : ~lastVal);

    // idle state: strobes inactive, bus released
    initial
    begin
        activeHigh      = 1'b1;
        drive           = 1'b0;
        driveData       = 8'h00;
        lastVal         = 8'h00;
        portChipSelect  = 1'b0;
        portReadStrobe  = 1'b0;
        portWriteStrobe = 1'b0;
    end

    // change polarity only while the port is disabled
    task automatic set_pol(input logic high);
        @(posedge core_clk);
        activeHigh = high;
        portChipSelect  <= ~high;
        portReadStrobe  <= ~high;
        portWriteStrobe <= ~high;
        repeat (6) @(posedge core_clk);
    endtask

    // one strobe cycle; write data held well past the strobe end
    task automatic strobe(input logic isWrite, input logic [7:0] data, output logic [7:0] seen);
        @(posedge core_clk);
        drive           <= isWrite;
        driveData       <= data;
        lastVal         <= data;
        portChipSelect  <= activeHigh;
        portReadStrobe  <= isWrite ? ~activeHigh : activeHigh;
        portWriteStrobe <= isWrite ? activeHigh : ~activeHigh;
        repeat (8) @(posedge core_clk);
        seen = portDataBusIn;
        lastVal         <= portDataBusIn;
        portChipSelect  <= ~activeHigh;
        portReadStrobe  <= ~activeHigh;
        portWriteStrobe <= ~activeHigh;
        repeat (6) @(posedge core_clk);
        drive <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

// *** verification/test_parallel_slave_port_buffered.sv ***
// testbench: register accesses and partner strobe cycles with expected values
// assumes a one-cycle register bus answer
`timescale 1ns/1ps
module test_parallel_slave_port_buffered;
    logic        core_clk;
    logic        arst_n;
    logic [13:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        portChipSelect;
    logic        portReadStrobe;
    logic        portWriteStrobe;
    logic [7:0]  portDataBusIn;
    logic [7:0]  portDataBusOut;
    logic        portDataBusOe;
    logic        portChipSelectOne;
    logic        portInterruptFlag;
    logic [7:0]  got;
    logic [31:0] word;
    logic [13:0] outAddr [4];
    int          errors;
    int          nTests;

    parallel_slave_port_buffered DUT (
        .core_clk(core_clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
        .waitrequest(waitrequest), .response(), .portChipSelect(portChipSelect),
        .portReadStrobe(portReadStrobe), .portWriteStrobe(portWriteStrobe),
        .portDataBusIn(portDataBusIn), .portDataBusOut(portDataBusOut),
        .portDataBusOe(portDataBusOe), .portChipSelectOne(portChipSelectOne),
        .portInterruptFlag(portInterruptFlag));

    host_cpu_model host (
        .core_clk(core_clk), .portChipSelect(portChipSelect), .portReadStrobe(portReadStrobe),
        .portWriteStrobe(portWriteStrobe), .portDataBusIn(portDataBusIn),
        .portDataBusOut(portDataBusOut), .portDataBusOe(portDataBusOe));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        nTests++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one register access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [13:0] addr, input logic [31:0] data,
                       output logic [31:0] seen);
        @(posedge core_clk);
        address   <= addr;
        read      <= ~wr;
        write     <= wr;
        writedata <= data;
        do
            @(posedge core_clk);
        while (waitrequest !== 1'b0);
        seen = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic reg_wr(input logic [13:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        bus(1'b1, addr, data, unused);
    endtask

    task automatic reg_chk(input string name, input logic [13:0] addr, input logic [31:0] exp);
        logic [31:0] seen;
        bus(1'b0, addr, 32'h0, seen);
        check(name, exp, seen);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // watchdog
    initial
    begin
        repeat (30000) @(posedge core_clk);
        errors++;
        print_verdict;
    end

    // test sequence
    initial
    begin
        arst_n = 1'b0;
        address = 14'h0000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        errors = 0;
        nTests = 0;
        outAddr = '{pport_pkg::OFF_ADDR_LOW, pport_pkg::OFF_ADDR_HIGH,
                    pport_pkg::OFF_OUT2_LOW, pport_pkg::OFF_OUT2_HIGH};
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        reg_chk("stat low reset", pport_pkg::OFF_STAT_LOW, 32'h8f);
        reg_chk("stat high reset", pport_pkg::OFF_STAT_HIGH, 32'h00);
        reg_chk("addr high reset", pport_pkg::OFF_ADDR_HIGH, 32'h00);
        reg_wr(14'h3000, 32'h5a);
        reg_chk("unmapped", 14'h3000, 32'h00);
        reg_wr(pport_pkg::OFF_CONTROL, 32'h0f);
        reg_wr(pport_pkg::OFF_MODE, 32'h00);
        host.strobe(1'b1, 8'ha5, got);
        check("interrupt", 32'h1, {31'h0, portInterruptFlag});
        bus(1'b0, pport_pkg::OFF_STAT_HIGH, 32'h0, word);
        check("all full", 32'h1, {31'h0, word[7]});
        reg_chk("input byte zero", pport_pkg::OFF_IN_BASE, 32'ha5);
        reg_wr(pport_pkg::OFF_IRQ, 32'h1);
        reg_wr(pport_pkg::OFF_ADDR_LOW, 32'h3c);
        host.strobe(1'b0, 8'h00, got);
        check("legacy read", 32'h3c, {24'h0, got});
        reg_wr(pport_pkg::OFF_IRQ, 32'h1);
        reg_wr(pport_pkg::OFF_MODE, 32'h02);
        host.strobe(1'b1, 8'h11, got);
        check("master mode ignored", 32'h0, {31'h0, portInterruptFlag});
        reg_wr(pport_pkg::OFF_MODE, 32'h58);
        for (int i = 0; i < 4; i++)
            reg_wr(outAddr[i], 32'hc0 + 32'(i));
        reg_chk("outputs loaded", pport_pkg::OFF_STAT_LOW, 32'h00);
        for (int i = 0; i < 4; i++)
        begin
            host.strobe(1'b0, 8'h00, got);
            check("buffered read", 32'hc0 + 32'(i), {24'h0, got});
            check("every strobe irq", 32'h1, {31'h0, portInterruptFlag});
            reg_wr(pport_pkg::OFF_IRQ, 32'h1);
        end
        reg_chk("outputs empty", pport_pkg::OFF_STAT_LOW, 32'h8f);
        host.strobe(1'b0, 8'h00, got);
        reg_chk("underflow", pport_pkg::OFF_STAT_LOW, 32'hcf);
        for (int i = 0; i < 4; i++)
            host.strobe(1'b1, 8'h50 + 8'(i), got);
        reg_chk("inputs full", pport_pkg::OFF_STAT_HIGH, 32'h8f);
        host.strobe(1'b1, 8'hee, got);
        reg_chk("overflow", pport_pkg::OFF_STAT_HIGH, 32'hcf);
        for (int i = 0; i < 4; i++)
            reg_chk("buffered write", pport_pkg::OFF_IN_BASE + 14'(4 * i), 32'h50 + 32'(i));
        reg_chk("overflow sticky", pport_pkg::OFF_STAT_HIGH, 32'h40);
        reg_wr(pport_pkg::OFF_STAT_HIGH, 32'h00);
        reg_chk("overflow cleared", pport_pkg::OFF_STAT_HIGH, 32'h00);
        // second reset puts both pointers back to buffer zero
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        reg_wr(pport_pkg::OFF_CONTROL, 32'h0f);
        reg_wr(pport_pkg::OFF_MODE, 32'hd8);
        for (int i = 0; i < 4; i++)
        begin
            host.strobe(1'b1, 8'h60 + 8'(i), got);
            check("fourth strobe irq", (i == 3) ? 32'h1 : 32'h0, {31'h0, portInterruptFlag});
        end
        for (int i = 0; i < 4; i++)
            reg_chk("ptr reset", pport_pkg::OFF_IN_BASE + 14'(4 * i), 32'h60 + 32'(i));
        reg_wr(pport_pkg::OFF_CONTROL, 32'h00);
        host.set_pol(1'b0);
        reg_wr(pport_pkg::OFF_CONTROL, 32'h01);
        reg_wr(pport_pkg::OFF_MODE, 32'h00);
        host.strobe(1'b1, 8'h77, got);
        reg_chk("active low write", pport_pkg::OFF_IN_BASE, 32'h77);
        reg_wr(pport_pkg::OFF_CONTROL, 32'h21);
        reg_wr(pport_pkg::OFF_ADDR_HIGH, 32'h40);
        reg_chk("addr high", pport_pkg::OFF_ADDR_HIGH, 32'h40);
        check("chip select one", 32'h1, {31'h0, portChipSelectOne});
        reg_wr(pport_pkg::OFF_ADDR_HIGH, 32'h00);
        repeat (2) @(posedge core_clk);
        check("chip select off", 32'h0, {31'h0, portChipSelectOne});
        print_verdict;
    end
endmodule
